// file: hw/ppfm_pkg.sv
`default_nettype none
package ppfm_pkg;
	localparam int unsigned ADDR_W = 3;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] OFS_P1_FUNC = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_P1_DIR  = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_P1_DATA = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_P2_DIR  = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_P2_DATA = 3'h4;
	localparam logic [ADDR_W-1:0] OFS_P5_FUNC = 3'h5;

	// Values after reset
	localparam logic [7:0] RST_P1_FUNC = 8'h00;
	localparam logic [7:0] RST_P1_DIR  = 8'h00;
	localparam logic [7:0] RST_P1_DATA = 8'h00;
	localparam logic [2:0] RST_P2_DIR  = 3'h0;
	localparam logic [2:0] RST_P2_DATA = 3'h0;
	localparam logic [7:0] RST_P5_FUNC = 8'h00;

	// Field positions and masks
	localparam int unsigned P1_FUNC_TXD_BIT  = 1;
	localparam int unsigned P1_FUNC_INT_BIT  = 4;
	localparam logic [7:0]  P1_FUNC_MASK     = 8'h12;
	localparam logic [7:0]  P1_PIN_MASK      = 8'hF7;
	localparam logic [7:0]  P1_DATA_ONES     = 8'h08;
	localparam int unsigned P1_INT_PIN       = 4;
	localparam logic [7:0]  P2_DATA_ONES     = 8'hF8;
	localparam int unsigned P2_SCK_PIN       = 0;
	localparam int unsigned P2_RXD_PIN       = 1;
	localparam int unsigned P2_TXD_PIN       = 2;
	localparam int unsigned P5_OD7_BIT       = 7;
	localparam int unsigned P5_OD6_BIT       = 6;
	localparam int unsigned P5_TRIG_BIT      = 5;
	localparam int unsigned P5_WAKE_W        = 6;

	// Serial unit on port 2
	typedef struct packed {
		logic clock_enable_high;
		logic clock_enable_low;
		logic sync_mode;
		logic receive_enable_bit;
		logic tx_enable;
		logic txd;
		logic sck_out;
	} ppfm_sci_ctrl_t;

	// Second serial unit on port 5
	typedef struct packed {
		logic tx_enable;
		logic txd;
		logic receive_enable_bit;
	} ppfm_sci5_ctrl_t;
endpackage : ppfm_pkg
`default_nettype wire

// file: hw/ppfm_sync.sv
`default_nettype none
module ppfm_sync #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	if (WIDTH < 1) begin : g_chk
		$error("ppfm_sync WIDTH must be at least 1");
	end

	// First stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : ppfm_sync
`default_nettype wire

// file: hw/ppfm_top.sv
// Notes on behaviour
// R1: Port 2 direction 1 drives, 0 inputs
// R2: Port 2 direction write-only, bits 2..0, reset 0
// R3: Port 2 data read returns latch when output
// R4: Port 2 data read returns pin when input
// R5: Port 2 data bits 7..3 read 1, unwritable
// R6: Port 2 data latch resets 0, drives outputs
// R7: Alternate function overrides general direction bit
// R8: Port 2 pins carry transmit, receive, clock
// R9: Mode bits 7,6 select open-drain output
// R10: Mode bit 5 selects wakeup and trigger input
// R11: Mode bits 4..0 select wakeup inputs
// R12: Mode register 8-bit read/write, reset 0
// R13: Port 5 also serves serial, trigger, wakeup
// R14: Port 1 select bit 1 gives transmit pin
// R15: Port 1 select bit 4 gives interrupt pin
// R16: Port 1 direction 1 drives, 0 inputs
// R17: Clock pin mode from clock-enable and sync bits
// R18: Receive enable makes receive pin input
// R19: Plain port 1 pins follow direction only
//
// Implementation choices: the placing of the registers and strobed register access.
`default_nettype none
module ppfm_top (
	input  wire logic                      CLK,
	input  wire logic                      NRST,
	input  wire logic [ppfm_pkg::ADDR_W-1:0] ADDR,
	input  wire logic [7:0]                WDATA,
	input  wire logic                      WR,
	input  wire logic                      RD,
	output var  logic [7:0]                RDATA,
	input  wire ppfm_pkg::ppfm_sci_ctrl_t  SCI_CTRL,
	output var  logic                      SCI_RXD,
	output var  logic                      SCI_SCK_IN,
	input  wire ppfm_pkg::ppfm_sci5_ctrl_t SCI5_CTRL,
	output var  logic                      SCI5_RXD,
	input  wire logic [7:0]                P1_I,
	output var  logic [7:0]                P1_O,
	output var  logic [7:0]                P1_OE,
	output var  logic                      EXT_INT0,
	input  wire logic [2:0]                P2_I,
	output var  logic [2:0]                P2_O,
	output var  logic [2:0]                P2_OE,
	input  wire logic [7:0]                P5_GPIO_O,
	input  wire logic [7:0]                P5_GPIO_OE,
	input  wire logic [7:0]                P5_I,
	output var  logic [7:0]                P5_O,
	output var  logic [7:0]                P5_OE,
	output var  logic [7:0]                P5_LEVEL,
	output var  logic [ppfm_pkg::P5_WAKE_W-1:0] WAKEUP,
	output var  logic                      CONV_TRIG
);
	logic       rst_meta_q;
	logic       rst_n_q;
	logic [7:0] p1_pin;
	logic [2:0] p2_pin;
	logic [7:0] p5_pin;

	logic [7:0] p1_func_q;
	logic [7:0] p1_dir_q;
	logic [7:0] p1_data_q;
	logic [2:0] p2_dir_q;
	logic [2:0] p2_data_q;
	logic [7:0] p5_func_q;

	logic [7:0] rdata_d;
	logic [7:0] p1_o_d;
	logic [7:0] p1_oe_d;
	logic [2:0] p2_o_d;
	logic [2:0] p2_oe_d;
	logic [7:0] p5_o_d;
	logic [7:0] p5_oe_d;
	logic       sci_rxd_d;
	logic       sci_sck_in_d;
	logic       sck_is_in;
	logic       sck_is_out;

	if (ppfm_pkg::ADDR_W < 3) begin : g_chk
		$error("ppfm_top needs at least three address bits");
	end

	// Readback mixes latch and live pin per direction bit
	function automatic logic [7:0] read_mix(
		input logic [7:0] dir,
		input logic [7:0] data,
		input logic [7:0] pin
	);
		read_mix = (dir & data) | (~dir & pin);
	endfunction : read_mix

	// Release of reset is synchronised; assertion stays immediate
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	ppfm_sync #(.WIDTH(8)) u_sync_p1 (
		.clk      (CLK),
		.rst_n    (rst_n_q),
		.async_in (P1_I),
		.sync_out (p1_pin)
	);

	ppfm_sync #(.WIDTH(3)) u_sync_p2 (
		.clk      (CLK),
		.rst_n    (rst_n_q),
		.async_in (P2_I),
		.sync_out (p2_pin)
	);

	ppfm_sync #(.WIDTH(8)) u_sync_p5 (
		.clk      (CLK),
		.rst_n    (rst_n_q),
		.async_in (P5_I),
		.sync_out (p5_pin)
	);

	// Port 1 register writes
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			p1_func_q <= ppfm_pkg::RST_P1_FUNC;
			p1_dir_q  <= ppfm_pkg::RST_P1_DIR;
			p1_data_q <= ppfm_pkg::RST_P1_DATA;
		end else if (WR) begin
			if (ADDR == ppfm_pkg::OFS_P1_FUNC) begin
				p1_func_q <= WDATA & ppfm_pkg::P1_FUNC_MASK;
			end
			if (ADDR == ppfm_pkg::OFS_P1_DIR) begin
				p1_dir_q <= WDATA & ppfm_pkg::P1_PIN_MASK;
			end
			if (ADDR == ppfm_pkg::OFS_P1_DATA) begin
				p1_data_q <= WDATA & ppfm_pkg::P1_PIN_MASK;
			end
		end
	end

	// Port 2 register writes; upper bits are dropped
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			p2_dir_q  <= ppfm_pkg::RST_P2_DIR; // R2
			p2_data_q <= ppfm_pkg::RST_P2_DATA; // R6
		end else if (WR) begin
			if (ADDR == ppfm_pkg::OFS_P2_DIR) begin
				p2_dir_q <= WDATA[2:0]; // R2
			end
			if (ADDR == ppfm_pkg::OFS_P2_DATA) begin
				p2_data_q <= WDATA[2:0]; // R5
			end
		end
	end

	// Port 5 mode register
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			p5_func_q <= ppfm_pkg::RST_P5_FUNC; // R12
		end else if (WR && ADDR == ppfm_pkg::OFS_P5_FUNC) begin
			p5_func_q <= WDATA; // R12
		end
	end

	// Read mux; direction registers are write-only and read 0
	always_comb begin
		rdata_d = 8'h00;
		if (RD) begin
			unique case (ADDR)
				ppfm_pkg::OFS_P1_FUNC: rdata_d = p1_func_q;
				ppfm_pkg::OFS_P1_DATA: begin
					rdata_d = read_mix(p1_dir_q, p1_data_q, p1_pin & ppfm_pkg::P1_PIN_MASK)
						| ppfm_pkg::P1_DATA_ONES;
				end
				ppfm_pkg::OFS_P2_DATA: begin
					rdata_d = read_mix({5'h00, p2_dir_q}, {5'h00, p2_data_q},
						{5'h00, p2_pin}) | ppfm_pkg::P2_DATA_ONES; // R3 R4 R5
				end
				ppfm_pkg::OFS_P5_FUNC: rdata_d = p5_func_q; // R12
				default:               rdata_d = 8'h00;
			endcase
		end
	end

	// Port 1 pin functions
	always_comb begin
		p1_o_d  = p1_data_q;
		p1_oe_d = p1_dir_q & ppfm_pkg::P1_PIN_MASK; // R16 R19
		if (p1_func_q[ppfm_pkg::P1_FUNC_INT_BIT]) begin
			p1_oe_d[ppfm_pkg::P1_INT_PIN] = 1'b0; // R15 R7
		end
	end

	// Serial clock pin direction
	always_comb begin
		sck_is_in  = SCI_CTRL.clock_enable_high; // R17
		sck_is_out = !SCI_CTRL.clock_enable_high
			&& (SCI_CTRL.clock_enable_low || SCI_CTRL.sync_mode); // R17
	end

	// Port 2 pin functions; serial settings win over direction
	always_comb begin
		p2_o_d       = p2_data_q; // R6
		p2_oe_d      = p2_dir_q; // R1
		sci_rxd_d    = 1'b1;
		sci_sck_in_d = 1'b0;
		if (p1_func_q[ppfm_pkg::P1_FUNC_TXD_BIT]) begin
			p2_o_d[ppfm_pkg::P2_TXD_PIN]  = SCI_CTRL.txd; // R14 R8
			p2_oe_d[ppfm_pkg::P2_TXD_PIN] = 1'b1; // R7
		end
		if (SCI_CTRL.receive_enable_bit) begin
			p2_oe_d[ppfm_pkg::P2_RXD_PIN] = 1'b0; // R18 R7
			sci_rxd_d = p2_pin[ppfm_pkg::P2_RXD_PIN]; // R8
		end
		if (sck_is_in) begin
			p2_oe_d[ppfm_pkg::P2_SCK_PIN] = 1'b0; // R17 R7
			sci_sck_in_d = p2_pin[ppfm_pkg::P2_SCK_PIN]; // R8
		end else if (sck_is_out) begin
			p2_o_d[ppfm_pkg::P2_SCK_PIN]  = SCI_CTRL.sck_out; // R8
			p2_oe_d[ppfm_pkg::P2_SCK_PIN] = 1'b1; // R7
		end
	end

	// Port 5 pin functions; open drain only ever pulls low
	always_comb begin
		p5_o_d  = P5_GPIO_O;
		p5_oe_d = P5_GPIO_OE;
		if (SCI5_CTRL.tx_enable) begin
			p5_o_d[7]  = SCI5_CTRL.txd; // R13
			p5_oe_d[7] = 1'b1; // R7
		end
		if (SCI5_CTRL.receive_enable_bit) begin
			p5_oe_d[6] = 1'b0; // R13 R7
		end
		for (int i = 0; i < ppfm_pkg::P5_WAKE_W; i++) begin
			if (p5_func_q[i]) begin
				p5_oe_d[i] = 1'b0; // R10 R11 R7
			end
		end
		for (int i = ppfm_pkg::P5_OD6_BIT; i <= ppfm_pkg::P5_OD7_BIT; i++) begin
			if (p5_func_q[i]) begin
				p5_oe_d[i] = p5_oe_d[i] & ~p5_o_d[i]; // R9
				p5_o_d[i]  = 1'b0; // R9
			end
		end
	end

	// Read data stands for the cycle after the strobe only
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			RDATA <= 8'h00;
		end else begin
			RDATA <= rdata_d;
		end
	end

	// Registered pin drivers keep glitches off the pads
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			P1_O  <= 8'h00;
			P1_OE <= 8'h00;
			P2_O  <= 3'h0;
			P2_OE <= 3'h0;
			P5_O  <= 8'h00;
			P5_OE <= 8'h00;
		end else begin
			P1_O  <= p1_o_d;
			P1_OE <= p1_oe_d;
			P2_O  <= p2_o_d;
			P2_OE <= p2_oe_d;
			P5_O  <= p5_o_d;
			P5_OE <= p5_oe_d;
		end
	end

	// Inputs to peripherals; gated inputs idle so no false events
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			SCI_RXD    <= 1'b1;
			SCI_SCK_IN <= 1'b0;
			SCI5_RXD   <= 1'b1;
			EXT_INT0   <= 1'b0;
			WAKEUP     <= '0;
			CONV_TRIG  <= 1'b0;
			P5_LEVEL   <= 8'h00;
		end else begin
			SCI_RXD    <= sci_rxd_d; // R18
			SCI_SCK_IN <= sci_sck_in_d; // R17
			SCI5_RXD   <= SCI5_CTRL.receive_enable_bit ? p5_pin[6] : 1'b1; // R13
			EXT_INT0   <= p1_func_q[ppfm_pkg::P1_FUNC_INT_BIT]
				& p1_pin[ppfm_pkg::P1_INT_PIN]; // R15
			WAKEUP     <= p5_func_q[ppfm_pkg::P5_WAKE_W-1:0]
				& p5_pin[ppfm_pkg::P5_WAKE_W-1:0]; // R10 R11
			CONV_TRIG  <= p5_func_q[ppfm_pkg::P5_TRIG_BIT]
				& p5_pin[ppfm_pkg::P5_TRIG_BIT]; // R10
			P5_LEVEL   <= p5_pin;
		end
	end
endmodule : ppfm_top
`default_nettype wire

// file: test/ppfm_pins_model.sv
`default_nettype none
module ppfm_pins_model #(
	parameter int unsigned W = 8
) (
	input  wire logic [W-1:0] oe,
	input  wire logic [W-1:0] o,
	input  wire logic [W-1:0] ext,
	output var  logic [W-1:0] lvl
);
	// Outside drivers give way to a driving pin, so contention never shows as X
	assign lvl = (oe & o) | (~oe & ext);
endmodule : ppfm_pins_model
`default_nettype wire

// file: test/ppfm_top_asserts.sv
`default_nettype none
module ppfm_top_asserts (
	input wire logic                            CLK,
	input wire logic                            NRST,
	input wire logic [ppfm_pkg::ADDR_W-1:0]     ADDR,
	input wire logic                            RD,
	input wire logic [7:0]                      RDATA,
	input wire ppfm_pkg::ppfm_sci_ctrl_t        SCI_CTRL,
	input wire logic                            SCI_RXD,
	input wire logic [7:0]                      P1_I,
	input wire logic                            EXT_INT0,
	input wire logic [2:0]                      P2_O,
	input wire logic [2:0]                      P2_OE,
	input wire logic [7:0]                      P5_I,
	input wire logic [ppfm_pkg::P5_WAKE_W-1:0]  WAKEUP,
	input wire logic                            CONV_TRIG
);
	logic [1:0] up_q;
	logic       live;
	logic       sck_drv;
	// Outputs only follow their causes from the third edge after release
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			up_q <= 2'h0;
		end else if (up_q != 2'h3) begin
			up_q <= up_q + 2'h1;
		end
	end
	assign live = up_q == 2'h3;
	assign sck_drv = !SCI_CTRL.clock_enable_high
		&& (SCI_CTRL.clock_enable_low || SCI_CTRL.sync_mode);
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	a_dir_wo: assert property (RD && ADDR == ppfm_pkg::OFS_P2_DIR |=> RDATA == 8'h00)
		else $error("direction read not zero");
	a_p2_upper: assert property (RD && ADDR == ppfm_pkg::OFS_P2_DATA |=> RDATA[7:3] == 5'h1F)
		else $error("upper data bits not ones");
	a_wake_pin: assert property (live |-> (WAKEUP & ~$past(P5_I[5:0], 3)) == 6'h00)
		else $error("wakeup without pin");
	a_trig_pin: assert property (CONV_TRIG |-> $past(P5_I[5], 3))
		else $error("trigger without pin");
	a_irq_pin: assert property (EXT_INT0 |-> $past(P1_I[4], 3))
		else $error("interrupt without pin");
	a_rx_input: assert property (live && $past(SCI_CTRL.receive_enable_bit) |-> !P2_OE[1])
		else $error("receive pin driven");
	a_rxd_idle: assert property (live && !$past(SCI_CTRL.receive_enable_bit) |-> SCI_RXD)
		else $error("receive data not idle");
	a_sck_mode: assert property (live && $past(sck_drv) |->
		P2_OE[0] && P2_O[0] == $past(SCI_CTRL.sck_out))
		else $error("clock pin not driven");
	c_sck_in: cover property (live && SCI_CTRL.clock_enable_high);
	c_trig: cover property (CONV_TRIG);
	c_irq: cover property (EXT_INT0);
endmodule : ppfm_top_asserts
bind ppfm_top ppfm_top_asserts u_chk (.CLK, .NRST, .ADDR, .RD, .RDATA, .SCI_CTRL, .SCI_RXD,
	.P1_I, .EXT_INT0, .P2_O, .P2_OE, .P5_I, .WAKEUP, .CONV_TRIG);
`default_nettype wire

// file: test/ppfm_top_bench.sv
`default_nettype none
module ppfm_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [2:0] wa;
		logic [7:0] wd;
		logic [2:0] ra;
		logic [7:0] rd;
		logic [2:0] oe;
		logic [2:0] o;
		logic [6:0] wk;
	} ppfm_row_t;
	logic CLK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0;
	logic [2:0] ADDR = 3'h0, ext2 = 3'h5;
	logic [7:0] WDATA = 8'h00, P5_GPIO_O = 8'h00, P5_GPIO_OE = 8'h00;
	logic [7:0] ext1 = 8'h10, ext5 = 8'hFF;
	ppfm_pkg::ppfm_sci_ctrl_t  SCI_CTRL = 7'h00;
	ppfm_pkg::ppfm_sci5_ctrl_t SCI5_CTRL = 3'h0;
	wire logic [7:0] RDATA, P1_I, P1_O, P1_OE, P5_I, P5_O, P5_OE, P5_LEVEL;
	wire logic [2:0] P2_I, P2_O, P2_OE;
	wire logic [5:0] WAKEUP;
	wire logic       SCI_RXD, SCI_SCK_IN, SCI5_RXD, EXT_INT0, CONV_TRIG;
	wire logic [4:0] p2v = {P2_OE[1:0], P2_O[0] & P2_OE[0], SCI_SCK_IN, SCI_RXD};
	int error_cnt = 0;
	int comparisons = 0;
	ppfm_row_t rows [8] = '{
		{3'h4, 8'hFF, 3'h4, 8'hFD, 3'h0, 3'h0, 7'h00},
		{3'h3, 8'h07, 3'h4, 8'hFF, 3'h7, 3'h7, 7'h00},
		{3'h4, 8'h02, 3'h4, 8'hFA, 3'h7, 3'h2, 7'h00},
		{3'h3, 8'h05, 3'h4, 8'hF8, 3'h5, 3'h0, 7'h00},
		{3'h3, 8'h00, 3'h3, 8'h00, 3'h0, 3'h0, 7'h00},
		{3'h5, 8'hA5, 3'h5, 8'hA5, 3'h0, 3'h0, 7'h65},
		{3'h5, 8'h5A, 3'h5, 8'h5A, 3'h0, 3'h0, 7'h1A},
		{3'h7, 8'hFF, 3'h7, 8'h00, 3'h0, 3'h0, 7'h1A}
	};
	// Serial control, then expected p2v
	logic [11:0] modes [5] = '{12'h039, 12'h23D, 12'h43D, 12'h833, 12'h108};
	ppfm_top uut (
		.CLK, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .SCI_CTRL, .SCI_RXD, .SCI_SCK_IN,
		.SCI5_CTRL, .SCI5_RXD, .P1_I, .P1_O, .P1_OE, .EXT_INT0, .P2_I, .P2_O, .P2_OE,
		.P5_GPIO_O, .P5_GPIO_OE, .P5_I, .P5_O, .P5_OE, .P5_LEVEL, .WAKEUP, .CONV_TRIG
	);
	ppfm_pins_model #(.W(8)) pins1 (.oe(P1_OE), .o(P1_O), .ext(ext1), .lvl(P1_I));
	ppfm_pins_model #(.W(3)) pins2 (.oe(P2_OE), .o(P2_O), .ext(ext2), .lvl(P2_I));
	ppfm_pins_model #(.W(8)) pins5 (.oe(P5_OE), .o(P5_O), .ext(ext5), .lvl(P5_I));
	always #20 CLK = ~CLK;
	task automatic give_verdict;
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic st(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask : st
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask : wr
	// Read data stands for one cycle only, so it is taken just after the edge
	task automatic rdc(input logic [2:0] a, input logic [7:0] e);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1;
		chk("RDATA", e, RDATA);
	endtask : rdc
	initial begin
		#20000;
		error_cnt++;
		give_verdict();
	end
	initial begin
		repeat (5) @(posedge CLK);
		NRST <= 1'b1;
		st(3);
		for (int i = 0; i < 8; i++) begin
			wr(rows[i].wa, rows[i].wd);
			st(3);
			chk("P2_OE", rows[i].oe, P2_OE);
			chk("P2_O", rows[i].o, P2_O & P2_OE);
			chk("WAKEUP", rows[i].wk, {CONV_TRIG, WAKEUP});
			rdc(rows[i].ra, rows[i].rd);
		end
		wr(3'h0, 8'h02);
		SCI_CTRL <= 7'h02;
		st(3);
		chk("tx pin", 8'h03, {P2_OE[2], P2_O[2]});
		@(posedge CLK);
		SCI_CTRL <= 7'h00;
		st(3);
		chk("tx pin", 8'h02, {P2_OE[2], P2_O[2]});
		wr(3'h3, 8'h03);
		for (int i = 0; i < 5; i++) begin
			@(posedge CLK);
			SCI_CTRL <= modes[i][11:5];
			// A pin released by the mode change needs pin, two syncs and output edge
			st(4);
			chk("serial pins", {3'h0, modes[i][4:0]}, p2v);
		end
		wr(3'h1, 8'h11);
		wr(3'h2, 8'h11);
		wr(3'h0, 8'h12);
		st(3);
		chk("port1", 8'h07, {P1_OE[4], P1_OE[0], P1_O[0], EXT_INT0});
		wr(3'h5, 8'hC0);
		P5_GPIO_OE <= 8'hC0;
		P5_GPIO_O <= 8'h80;
		st(3);
		chk("open drain", 8'h04, {P5_OE[7:6], P5_O[7:6]});
		wr(3'h5, 8'h00);
		SCI5_CTRL <= 3'h4;
		st(4);
		chk("serial5 tx", 8'h02, {P5_OE[7], P5_O[7]});
		chk("P5_LEVEL", 8'h3F, P5_LEVEL);
		@(posedge CLK);
		SCI5_CTRL <= 3'h1;
		st(5);
		chk("serial5 rx", 8'h01, {P5_OE[6], SCI5_RXD});
		@(posedge CLK);
		NRST <= 1'b0;
		st(1);
		chk("reset pins", 8'h01, {P2_OE, SCI_RXD});
		@(posedge CLK);
		NRST <= 1'b1;
		st(3);
		rdc(3'h5, 8'h00);
		rdc(3'h4, 8'hFD);
		give_verdict();
	end
endmodule : ppfm_top_bench
`default_nettype wire
